// ---- esr_pkg.sv ----
// Package of constants and types for the edge-strobed static RAM host controller
package esr_pkg;
   localparam int ADDR_W     = 12;
   localparam int CLK_NS     = 100;
   // Strobe timing, ns, slowest grade figures
   localparam int EH_NS      = 500;  // Strobe high time
   localparam int EL_NS      = 300;  // Strobe low time
   localparam int ACC_NS     = 500;  // Access time from strobe rise
   localparam int WE_DLY_NS  = 50;   // Write pulse starts after this
   localparam int WW_NS      = 300;  // Write pulse width
   localparam int CF_NS      = 210;  // output_turnoff_delay
   localparam int DS_NS      = 300;  // write_data_setup
   localparam int CNT_W      = 4;
   // Least times round up
   localparam logic [CNT_W-1:0] EH_CYC  = CNT_W'((EH_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [CNT_W-1:0] EL_CYC  = CNT_W'((EL_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [CNT_W-1:0] ACC_CYC = CNT_W'((ACC_NS + CLK_NS - 1) / CLK_NS);
   // Write pulse waits strictly more than the delay, then holds pulse width plus turn-off
   localparam logic [CNT_W-1:0] WE_DLY_CYC = CNT_W'(WE_DLY_NS / CLK_NS + 1);
   localparam logic [CNT_W-1:0] WW_CYC =
      CNT_W'((WW_NS + CF_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [CNT_W-1:0] ONE = CNT_W'(1);
   typedef enum logic [2:0] {ESR_IDLE, ESR_OFF, ESR_HIGH, ESR_WPULSE, ESR_LOW} esr_state_t;
endpackage

// ---- esr_tmr_if.sv ----
// Interface carrying the interval timer load and done signals
interface esr_tmr_if;
   logic                             load;
   logic [esr_pkg::CNT_W-1:0]        count;
   logic                             done;
   modport ctl (output load, output count, input done);
   modport tmr (input load, input count, output done);
endinterface

// ---- esr_timer.sv ----
// Down counter that times strobe phases in clock cycles
module esr_timer (
   input  wire logic clk,
   input  wire logic rstn,
   esr_tmr_if.tmr    t
);
   logic [esr_pkg::CNT_W-1:0] cnt_ff;
   logic [esr_pkg::CNT_W-1:0] nxt_cnt;

   always_comb begin
      nxt_cnt = cnt_ff;
      if (t.load) begin
         nxt_cnt = t.count - esr_pkg::ONE;
      end else if (cnt_ff != '0) begin
         nxt_cnt = cnt_ff - esr_pkg::ONE;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cnt_ff <= '0;
      end else begin
         cnt_ff <= nxt_cnt;
      end
   end

   // Done while idle; a load of N raises it N edges later.
   // Done must not look at load, which is itself decoded from done.
   assign t.done = (cnt_ff == '0);
endmodule

// ---- esr_ctrl.sv ----
// Host controller that runs strobed read and write cycles on the static RAM
module esr_ctrl #(
   parameter int ADDR_W = esr_pkg::ADDR_W
) (
   input  wire logic              clk,
   input  wire logic              rstn,
   input  wire logic              req_valid,
   input  wire logic              req_write,
   input  wire logic [ADDR_W-1:0] req_addr,
   input  wire logic              req_wdata,
   output logic                   req_ready,
   output logic                   rsp_valid,
   output logic                   rsp_rdata,
   output logic                   mem_strobe,
   output logic [ADDR_W-1:0]      mem_addr,
   output logic                   mem_select_n,
   output logic                   mem_write_n,
   output logic                   mem_din,
   output logic                   mem_output_on,
   output logic                   output_off_control,
   input  wire logic              mem_dout,
   input  wire logic              mem_dout_oe,
   input  wire logic              mem_status
);
   esr_tmr_if tif ();

   esr_timer u_timer (
      .clk  (clk),
      .rstn (rstn),
      .t    (tif)
   );

   esr_pkg::esr_state_t   state_ff;
   esr_pkg::esr_state_t   nxt_state;
   logic                  wr_ff;
   logic                  nxt_wr;
   logic                  strobe_ff;
   logic                  nxt_strobe;
   logic [ADDR_W-1:0]     addr_ff;
   logic [ADDR_W-1:0]     nxt_addr;
   logic                  wen_n_ff;
   logic                  nxt_wen_n;
   logic                  din_ff;
   logic                  nxt_din;
   logic                  oon_ff;
   logic                  nxt_oon;
   logic                  ooff_ff;
   logic                  nxt_ooff;
   logic                  rv_ff;
   logic                  nxt_rv;
   logic                  rd_ff;
   logic                  nxt_rd;
   logic                  min_ok_ff;
   logic                  nxt_min_ok;

   always_comb begin
      nxt_state  = state_ff;
      nxt_wr     = wr_ff;
      nxt_strobe = strobe_ff;
      nxt_addr   = addr_ff;
      nxt_wen_n  = wen_n_ff;
      nxt_din    = din_ff;
      nxt_oon    = oon_ff;
      nxt_ooff   = ooff_ff;
      nxt_rv     = 1'b0;
      nxt_rd     = rd_ff;
      nxt_min_ok = min_ok_ff;
      tif.load   = 1'b0;
      tif.count  = esr_pkg::ONE;
      case (state_ff)
         esr_pkg::ESR_IDLE: begin
            if (req_valid && tif.done) begin
               nxt_wr   = req_write;
               nxt_addr = req_addr;
               nxt_din  = req_wdata;
               if (req_write) begin
                  nxt_oon   = 1'b0;
                  nxt_ooff  = 1'b1;
                  tif.load  = 1'b1;
                  tif.count = esr_pkg::ONE;
                  nxt_state = esr_pkg::ESR_OFF;
               end else begin
                  nxt_oon    = 1'b1;
                  nxt_ooff   = 1'b0;
                  nxt_strobe = 1'b1;
                  tif.load   = 1'b1;
                  tif.count  = esr_pkg::EH_CYC;
                  nxt_min_ok = 1'b0;
                  nxt_state  = esr_pkg::ESR_HIGH;
               end
            end
         end
         esr_pkg::ESR_OFF: begin
            // Lets the memory output fall off the data line before the write strobe
            if (tif.done) begin
               nxt_strobe = 1'b1;
               tif.load   = 1'b1;
               tif.count  = esr_pkg::WE_DLY_CYC;
               nxt_state  = esr_pkg::ESR_HIGH;
            end
         end
         esr_pkg::ESR_HIGH: begin
            if (wr_ff) begin
               if (tif.done) begin
                  nxt_wen_n = 1'b0;
                  tif.load  = 1'b1;
                  tif.count = esr_pkg::WW_CYC;
                  nxt_state = esr_pkg::ESR_WPULSE;
               end
            end else begin
               if (tif.done) begin
                  nxt_min_ok = 1'b1;
               end
               // Status ends the read cycle, but only once the least high time has passed
               if ((tif.done || min_ok_ff) && mem_status && mem_dout_oe) begin
                  nxt_rd     = mem_dout;
                  nxt_rv     = 1'b1;
                  nxt_strobe = 1'b0;
                  tif.load   = 1'b1;
                  tif.count  = esr_pkg::EL_CYC;
                  nxt_state  = esr_pkg::ESR_LOW;
               end
            end
         end
         esr_pkg::ESR_WPULSE: begin
            if (tif.done) begin
               nxt_wen_n  = 1'b1;
               nxt_strobe = 1'b0;
               tif.load   = 1'b1;
               tif.count  = esr_pkg::EL_CYC;
               nxt_state  = esr_pkg::ESR_LOW;
            end
         end
         esr_pkg::ESR_LOW: begin
            if (tif.done) begin
               nxt_state = esr_pkg::ESR_IDLE;
            end
         end
         default: begin
            nxt_state = esr_pkg::ESR_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state_ff  <= esr_pkg::ESR_IDLE;
         wr_ff     <= 1'b0;
         strobe_ff <= 1'b0;
         addr_ff   <= '0;
         wen_n_ff  <= 1'b1;
         din_ff    <= 1'b0;
         oon_ff    <= 1'b0;
         ooff_ff   <= 1'b1;
         rv_ff     <= 1'b0;
         rd_ff     <= 1'b0;
         min_ok_ff <= 1'b0;
      end else begin
         state_ff  <= nxt_state;
         wr_ff     <= nxt_wr;
         strobe_ff <= nxt_strobe;
         addr_ff   <= nxt_addr;
         wen_n_ff  <= nxt_wen_n;
         din_ff    <= nxt_din;
         oon_ff    <= nxt_oon;
         ooff_ff   <= nxt_ooff;
         rv_ff     <= nxt_rv;
         rd_ff     <= nxt_rd;
         min_ok_ff <= nxt_min_ok;
      end
   end

   // Address and data are held through the whole cycle, beyond the hold minima
   assign req_ready          = (state_ff == esr_pkg::ESR_IDLE) && tif.done;
   assign rsp_valid          = rv_ff;
   assign rsp_rdata          = rd_ff;
   assign mem_strobe         = strobe_ff;
   assign mem_addr           = addr_ff;
   assign mem_select_n       = 1'b0;
   assign mem_write_n        = wen_n_ff;
   assign mem_din            = din_ff;
   assign mem_output_on      = oon_ff;
   assign output_off_control = ooff_ff;
endmodule

// ---- esr_mem_model.sv ----
// Behavioural model of the strobed 4096 x 1 static memory
module esr_mem_model (
   input  wire logic        clk,
   input  wire logic        slow,
   input  wire logic        strobe,
   input  wire logic [11:0] addr,
   input  wire logic        select_n,
   input  wire logic        write_n,
   input  wire logic        din,
   input  wire logic        out_on,
   input  wire logic        out_off,
   output logic             dout,
   output logic             dout_oe,
   output logic             status
);
   timeunit 1ns;
   timeprecision 1ns;
   logic        mem [4096];
   logic [11:0] a_q;
   logic        sel_q;
   logic        q;
   logic        s_q;
   int          cnt;
   // Capture at the first clock edge that sees the strobe high, clear of the launch race;
   // later address and select changes are ignored until the next rise
   always @(posedge clk) begin
      s_q <= strobe;
      if (strobe && !s_q) {a_q, sel_q} <= {addr, select_n};
   end
   // Last data seen with the pulse low wins, so hold matters up to the strobe fall
   always @(posedge clk) if (strobe && !write_n && !sel_q) mem[a_q] <= din;
   always @(posedge clk) cnt <= strobe ? cnt + 1 : 0;
   assign status = strobe && write_n && !sel_q && cnt >= (slow ? 9 : 2);
   always @(posedge status) q = mem[a_q];
   assign dout_oe = out_on && !out_off;
   // Released output shows the inverse so a stale value never passes
   assign dout = dout_oe ? q : ~q;
endmodule

// ---- esr_ctrl_assertions.sv ----
// Checker of the controller pin timing
module esr_ctrl_chk #(
   parameter int ADDR_W = esr_pkg::ADDR_W
) (
   input wire logic              clk,
   input wire logic              rstn,
   input wire logic              rsp_valid,
   input wire logic              rsp_rdata,
   input wire logic              mem_strobe,
   input wire logic [ADDR_W-1:0] mem_addr,
   input wire logic              mem_select_n,
   input wire logic              mem_write_n,
   input wire logic              mem_din,
   input wire logic              mem_output_on,
   input wire logic              output_off_control,
   input wire logic              mem_dout,
   input wire logic              mem_dout_oe,
   input wire logic              mem_status
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   a_wr_out_off: assert property (!mem_write_n |-> !mem_output_on && output_off_control)
      else $error("output enabled during write");
   a_wn_in_strobe: assert property (!mem_write_n |-> mem_strobe)
      else $error("write pulse outside strobe");
   a_strobe_high: assert property ($rose(mem_strobe) |-> mem_strobe[*5])
      else $error("strobe high too short");
   a_strobe_low: assert property ($fell(mem_strobe) |-> !mem_strobe[*3])
      else $error("strobe low too short");
   a_we_delay: assert property ($rose(mem_strobe) |-> mem_write_n)
      else $error("write pulse starts with strobe");
   a_we_width: assert property ($fell(mem_write_n) |-> !mem_write_n[*6])
      else $error("write pulse too short");
   a_write_end: assert property ($rose(mem_write_n) |-> $fell(mem_strobe))
      else $error("write end not at strobe fall");
   a_hold_pins: assert property (mem_strobe && $past(mem_strobe) |-> $stable(mem_addr) && $stable(mem_din))
      else $error("address or data moved in cycle");
   a_rsp_data: assert property (rsp_valid |-> $past(mem_status && mem_dout_oe) && rsp_rdata == $past(mem_dout))
      else $error("read answer without valid data");
   a_select_on: assert property (mem_select_n == 1'b0)
      else $error("memory deselected");
   c_read: cover property ($rose(mem_strobe) && mem_output_on);
   c_write: cover property ($fell(mem_write_n));
   c_answer: cover property (rsp_valid);
endmodule
bind esr_ctrl esr_ctrl_chk #(.ADDR_W(ADDR_W)) u_chk (.clk(clk), .rstn(rstn),
   .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .mem_strobe(mem_strobe), .mem_addr(mem_addr),
   .mem_select_n(mem_select_n), .mem_write_n(mem_write_n), .mem_din(mem_din),
   .mem_output_on(mem_output_on), .output_off_control(output_off_control),
   .mem_dout(mem_dout), .mem_dout_oe(mem_dout_oe), .mem_status(mem_status));

// ---- esr_ctrl_test.sv ----
// Self-checking bench of the strobed RAM host controller
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin num_errors++; \
   $display("ERROR t=%0t got %h exp %h", $time, a, b); end end
module esr_ctrl_test;
   timeunit 1ns;
   timeprecision 1ns;
   logic                       clk, rstn, req_valid, req_write, req_wdata, slow;
   logic [esr_pkg::ADDR_W-1:0] req_addr, mem_addr;
   logic                       req_ready, rsp_valid, rsp_rdata, strobe, sel_n, wr_n;
   logic                       din, out_on, out_off, dout, dout_oe, status;
   int                         num_errors = 0, compares = 0, cycles = 0;
   esr_ctrl u_dut (.clk(clk), .rstn(rstn), .req_valid(req_valid), .req_write(req_write),
      .req_addr(req_addr), .req_wdata(req_wdata), .req_ready(req_ready),
      .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .mem_strobe(strobe), .mem_addr(mem_addr),
      .mem_select_n(sel_n), .mem_write_n(wr_n), .mem_din(din), .mem_output_on(out_on),
      .output_off_control(out_off), .mem_dout(dout), .mem_dout_oe(dout_oe), .mem_status(status));
   esr_mem_model u_mem (.clk(clk), .slow(slow), .strobe(strobe), .addr(mem_addr),
      .select_n(sel_n), .write_n(wr_n), .din(din), .out_on(out_on), .out_off(out_off),
      .dout(dout), .dout_oe(dout_oe), .status(status));
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   task automatic stop_test();
      $display("errors %0d compares %0d", num_errors, compares);
      if (num_errors == 0 && compares > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // A hung memory handshake stalls forever, so cap the run
   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         num_errors++;
         stop_test();
      end
   end
   task automatic issue(input logic w, input logic [11:0] a, input logic d);
      @(posedge clk);
      req_valid <= 1'b1;
      req_write <= w;
      req_addr <= a;
      req_wdata <= d;
      do @(posedge clk); while (req_ready !== 1'b1);
      req_valid <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input logic d);
      issue(1'b1, a, d);
      repeat (10) begin
         @(posedge clk);
         if (wr_n === 1'b0) break;
      end
      `CHK(wr_n, 1'b0)
      `CHK(dout_oe, 1'b0)
      `CHK(sel_n, 1'b0)
   endtask
   task automatic rd(input logic [11:0] a, input logic exp);
      issue(1'b0, a, 1'b0);
      repeat (30) begin
         @(posedge clk);
         if (rsp_valid === 1'b1) break;
      end
      `CHK(rsp_valid, 1'b1)
      `CHK(rsp_rdata, exp)
   endtask
   task automatic t_edges();
      wr(12'h000, 1'b1);
      wr(12'hFFF, 1'b0);
      wr(12'h555, 1'b1);
      wr(12'hAAA, 1'b0);
      rd(12'h000, 1'b1);
      rd(12'hFFF, 1'b0);
      rd(12'h555, 1'b1);
      rd(12'hAAA, 1'b0);
   endtask
   task automatic t_overwrite();
      wr(12'h123, 1'b1);
      wr(12'h123, 1'b0);
      rd(12'h123, 1'b0);
      rd(12'h000, 1'b1);
   endtask
   task automatic t_slow_hold();
      slow <= 1'b1;
      wr(12'h007, 1'b1);
      rd(12'h007, 1'b1);
      wr(12'h007, 1'b0);
      `CHK(rsp_rdata, 1'b1)
      rd(12'h007, 1'b0);
      slow <= 1'b0;
   endtask
   task automatic t_reset();
      issue(1'b0, 12'h555, 1'b0);
      repeat (2) @(posedge clk);
      rstn <= 1'b0;
      repeat (2) @(posedge clk);
      `CHK(strobe, 1'b0)
      `CHK(wr_n, 1'b1)
      `CHK(out_on, 1'b0)
      `CHK(out_off, 1'b1)
      `CHK(rsp_valid, 1'b0)
      `CHK(rsp_rdata, 1'b0)
      `CHK(req_ready, 1'b1)
      rstn <= 1'b1;
      rd(12'h555, 1'b1);
   endtask
   initial begin
      rstn = 1'b0;
      req_valid = 1'b0;
      req_write = 1'b0;
      req_addr = '0;
      req_wdata = 1'b0;
      slow = 1'b0;
      repeat (8) @(posedge clk);
      rstn <= 1'b1;
      t_edges();
      t_overwrite();
      t_slow_hold();
      t_reset();
      stop_test();
   end
endmodule
